/* File: scru_top.sv */
// Function
// - Power-good input synchronised, active high
// - Hard reset starts on power-good rise
// - Drive board reset output to system
// - Crystal reference feeds the frequency synthesizer
// - Host clock programmable 25 to 75 MHz
// - Host transactions timed by host clock
// - Host clock generated internally, driven out
// - Graphics engine timed by 80 MHz clock
// - Strap bit turns graphics clock pin input
// - Buffered crystal clock output for expansion bus
// - Dot clock internal or external, strap selectable
// - Expansion clock divided; companion at double rate
// - Memory data 40:0 latched into straps
`timescale 1ns/1ps
`default_nettype none
`include "scru_regs.svh"
module scru_top
  import scru_pkg::*;
#(
  parameter int LOCK_EDGES = `SCRU_LOCK_EDGES,
  parameter int EXP_DIV    = `SCRU_EXP_DIV
) (
  input  wire logic                      REF_CLK_I,
  input  wire logic                      ARST_N_I,
  input  wire logic                      POWER_GOOD_RESET_IN_I,
  input  wire logic                      CRYSTAL_IN_I,
  input  wire logic                      CRYSTAL_OUT_OSC_IN_I,
  output logic                           CRYSTAL_OUT_OSC_IN_O,
  output logic                           CRYSTAL_OUT_OSC_IN_OE_O,
  input  wire logic [`SCRU_NCO_W-1:0]    HOST_INC_I,
  input  wire logic [`SCRU_NCO_W-1:0]    DOT_INC_I,
  input  wire logic                      DOT_EXT_SEL_I,
  input  wire logic                      EXP_SRC_LBUS_I,
  input  wire logic [`SCRU_STRAP_W-1:0]  MEM_DATA_I,
  input  wire logic                      LOCAL_BUS_CLOCK_IN_I,
  input  wire logic                      GRAPHICS_DOUBLE_CLOCK_I,
  output logic                           GRAPHICS_DOUBLE_CLOCK_O,
  output logic                           GRAPHICS_DOUBLE_CLOCK_OE_O,
  input  wire logic                      PIXEL_DOT_CLOCK_I,
  output logic                           PIXEL_DOT_CLOCK_O,
  output logic                           PIXEL_DOT_CLOCK_OE_O,
  output logic                           HOST_CLOCK_O,
  output logic                           HOST_TICK_O,
  output logic                           GFX_TICK_O,
  output logic                           DOT_TICK_O,
  output logic                           PERIPHERAL_24M_CLOCK_O,
  output logic                           LOCAL_BUS_CLOCK_OUT_O,
  output logic                           BUFFERED_CRYSTAL_CLOCK_O,
  output logic                           EXPANSION_BUS_CLOCK_O,
  output logic                           EXPANSION_BUS_CLOCK_X2_O,
  output logic                           BOARD_RESET_OUT_N_O,
  output logic [`SCRU_STRAP_W-1:0]       STRAP_O
);
  localparam int SETTLE_CYC = `SCRU_SETTLE_CYC;

  logic [`SCRU_PIN_W-1:0]   pin_raw;
  logic [`SCRU_PIN_W-1:0]   pin_s1_ff;
  logic [`SCRU_PIN_W-1:0]   pin_s2_ff;
  logic [`SCRU_PIN_W-1:0]   pin_s3_ff;
  logic [`SCRU_PIN_W-1:0]   pin_filt_ff;
  logic [`SCRU_PIN_W-1:0]   pin_prev_ff;
  logic [`SCRU_PIN_W-1:0]   pin_rise;
  logic [`SCRU_STRAP_W-1:0] md_s1_ff;
  logic [`SCRU_STRAP_W-1:0] md_s2_ff;
  logic [`SCRU_STRAP_W-1:0] md_s3_ff;
  logic [`SCRU_STRAP_W-1:0] strap_ff;
  logic [`SCRU_LOCK_W-1:0]  lock_cnt_ff;
  logic                     locked_ff;
  logic [15:0]              settle_cnt_ff;
  scru_state_t              state_ff;
  logic [`SCRU_NCO_W-1:0]   host_inc;
  logic [`SCRU_NCO_W-1:0]   inc_arr [`SCRU_NUM_CLK];
  scru_clk_vec_t            nco_clk;
  scru_clk_vec_t            nco_rise;
  logic                     gfx_ext;
  logic                     dot_ext;
  logic                     exp_src_rise;
  logic [`SCRU_EXP_CNT_W-1:0] exp_cnt_ff;

  // Pin lanes that cross into the core clock
  assign pin_raw = {PIXEL_DOT_CLOCK_I, GRAPHICS_DOUBLE_CLOCK_I,
                    LOCAL_BUS_CLOCK_IN_I, CRYSTAL_OUT_OSC_IN_I,
                    POWER_GOOD_RESET_IN_I};

  // Three-stage synchroniser; first stage feeds only the second
  always_ff @(posedge REF_CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      pin_s1_ff <= '0;
      pin_s2_ff <= '0;
      pin_s3_ff <= '0;
      md_s1_ff  <= '0;
      md_s2_ff  <= '0;
      md_s3_ff  <= '0;
    end
    else
    begin
      pin_s1_ff <= pin_raw;
      pin_s2_ff <= pin_s1_ff;
      pin_s3_ff <= pin_s2_ff;
      md_s1_ff  <= MEM_DATA_I;
      md_s2_ff  <= md_s1_ff;
      md_s3_ff  <= md_s2_ff;
    end
  end

  // Level accepted only once stages two and three agree
  always_ff @(posedge REF_CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      pin_filt_ff <= '0;
      pin_prev_ff <= '0;
    end
    else
    begin
      pin_filt_ff <= (~(pin_s2_ff ^ pin_s3_ff) & pin_s3_ff) |
                     ((pin_s2_ff ^ pin_s3_ff) & pin_filt_ff);
      pin_prev_ff <= pin_filt_ff;
    end
  end

  assign pin_rise = pin_filt_ff & ~pin_prev_ff;

  // Crystal amplifier stays on; an external oscillator has to overdrive the pin
  always_ff @(posedge REF_CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      CRYSTAL_OUT_OSC_IN_O    <= 1'b0;
      CRYSTAL_OUT_OSC_IN_OE_O <= 1'b0;
    end
    else
    begin
      CRYSTAL_OUT_OSC_IN_O    <= ~CRYSTAL_IN_I;
      CRYSTAL_OUT_OSC_IN_OE_O <= 1'b1;
    end
  end

  // Reference lock: count crystal edges before running the synthesizer
  always_ff @(posedge REF_CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      lock_cnt_ff <= '0;
      locked_ff   <= 1'b0;
    end
    else if (!pin_filt_ff[`SCRU_PIN_PG])
    begin
      lock_cnt_ff <= '0; // Fresh lock per hard reset, so a dead crystal holds reset
      locked_ff   <= 1'b0;
    end
    else if (!locked_ff && pin_rise[`SCRU_PIN_XTAL])
    begin
      lock_cnt_ff <= lock_cnt_ff + 1'b1;
      if (lock_cnt_ff == `SCRU_LOCK_W'(LOCK_EDGES - 1))
        locked_ff <= 1'b1;
    end
  end

  // Host rate clamped into its legal span
  always_comb
  begin
    host_inc = HOST_INC_I;
    if (HOST_INC_I < `SCRU_INC_HOST_MIN)
      host_inc = `SCRU_INC_HOST_MIN;
    else if (HOST_INC_I > `SCRU_INC_HOST_MAX)
      host_inc = `SCRU_INC_HOST_MAX;
  end

  assign inc_arr[`SCRU_IDX_HOST]   = host_inc;
  assign inc_arr[`SCRU_IDX_PERIPH] = `SCRU_INC_PERIPH;
  assign inc_arr[`SCRU_IDX_GFX]    = `SCRU_INC_GFX;
  assign inc_arr[`SCRU_IDX_DOT]    = DOT_INC_I;
  assign inc_arr[`SCRU_IDX_LBUS]   = `SCRU_INC_LBUS;

  // One synthesizer channel per clock, all from the locked reference
  for (genvar g = 0; g < `SCRU_NUM_CLK; g++)
  begin : g_nco
    scru_nco #(.W(`SCRU_NCO_W)) u_nco (
      .clk_i   (REF_CLK_I),
      .rst_n_i (ARST_N_I),
      .run_i   (locked_ff),
      .inc_i   (inc_arr[g]),
      .clk_o   (nco_clk[g]),
      .rise_o  (nco_rise[g])
    );
  end

  assign gfx_ext = strap_ff[`SCRU_STRAP_GFX_EXT];
  assign dot_ext = strap_ff[`SCRU_STRAP_DOT_EXT] | DOT_EXT_SEL_I;

  // Clock pins and enables; externally sourced clocks arrive via the filter
  always_ff @(posedge REF_CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      HOST_CLOCK_O               <= 1'b0;
      HOST_TICK_O                <= 1'b0;
      GRAPHICS_DOUBLE_CLOCK_O    <= 1'b0;
      GRAPHICS_DOUBLE_CLOCK_OE_O <= 1'b0;
      GFX_TICK_O                 <= 1'b0;
      PIXEL_DOT_CLOCK_O          <= 1'b0;
      PIXEL_DOT_CLOCK_OE_O       <= 1'b0;
      DOT_TICK_O                 <= 1'b0;
      PERIPHERAL_24M_CLOCK_O     <= 1'b0;
      LOCAL_BUS_CLOCK_OUT_O      <= 1'b0;
      BUFFERED_CRYSTAL_CLOCK_O   <= 1'b0;
    end
    else
    begin
      HOST_CLOCK_O               <= nco_clk.host;
      HOST_TICK_O                <= nco_rise.host;
      GRAPHICS_DOUBLE_CLOCK_O    <= nco_clk.gfx;
      GRAPHICS_DOUBLE_CLOCK_OE_O <= ~gfx_ext;
      GFX_TICK_O                 <= gfx_ext ? pin_rise[`SCRU_PIN_GFX]
                                            : nco_rise.gfx;
      PIXEL_DOT_CLOCK_O          <= nco_clk.dot;
      PIXEL_DOT_CLOCK_OE_O       <= ~dot_ext;
      DOT_TICK_O                 <= dot_ext ? pin_rise[`SCRU_PIN_DOT]
                                            : nco_rise.dot;
      PERIPHERAL_24M_CLOCK_O     <= nco_clk.periph;
      LOCAL_BUS_CLOCK_OUT_O      <= nco_clk.lbus;
      BUFFERED_CRYSTAL_CLOCK_O   <= pin_filt_ff[`SCRU_PIN_XTAL];
    end
  end

  // Expansion divider source: local bus input loop or crystal
  assign exp_src_rise = EXP_SRC_LBUS_I ? pin_rise[`SCRU_PIN_LBUS]
                                       : pin_rise[`SCRU_PIN_XTAL];

  // Double-rate output toggles every EXP_DIV source edges, base on its rise
  always_ff @(posedge REF_CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      exp_cnt_ff               <= '0;
      EXPANSION_BUS_CLOCK_X2_O <= 1'b0;
      EXPANSION_BUS_CLOCK_O    <= 1'b0;
    end
    else if (exp_src_rise)
    begin
      if (exp_cnt_ff == `SCRU_EXP_CNT_W'(EXP_DIV - 1))
      begin
        exp_cnt_ff               <= '0;
        EXPANSION_BUS_CLOCK_X2_O <= ~EXPANSION_BUS_CLOCK_X2_O;
        if (!EXPANSION_BUS_CLOCK_X2_O)
          EXPANSION_BUS_CLOCK_O <= ~EXPANSION_BUS_CLOCK_O;
      end
      else
        exp_cnt_ff <= exp_cnt_ff + 1'b1;
    end
  end

  // Hard reset sequencer; power-good low overrides everything
  always_ff @(posedge REF_CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      state_ff            <= ST_OFF;
      settle_cnt_ff       <= '0;
      BOARD_RESET_OUT_N_O <= 1'b0;
    end
    else if (!pin_filt_ff[`SCRU_PIN_PG])
    begin
      state_ff            <= ST_OFF;
      settle_cnt_ff       <= '0;
      BOARD_RESET_OUT_N_O <= 1'b0;
    end
    else
    begin
      case (state_ff)
        ST_OFF:
          if (pin_rise[`SCRU_PIN_PG])
            state_ff <= ST_CAPTURE;
        ST_CAPTURE:
          state_ff <= ST_LOCK;
        ST_LOCK:
          if (locked_ff)
            state_ff <= ST_SETTLE;
        ST_SETTLE:
        begin
          // Release only on a host edge so board logic sees a clean boundary
          if (settle_cnt_ff < 16'(SETTLE_CYC))
            settle_cnt_ff <= settle_cnt_ff + 1'b1;
          else if (nco_rise.host)
          begin
            state_ff            <= ST_RUN;
            BOARD_RESET_OUT_N_O <= 1'b1;
          end
        end
        ST_RUN:
          state_ff <= ST_RUN;
        default:
          state_ff <= ST_OFF;
      endcase
    end
  end

  // Strap capture at the power-good rise; held until the next one
  always_ff @(posedge REF_CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
      strap_ff <= '0;
    else if (state_ff == ST_CAPTURE)
      strap_ff <= md_s3_ff;
  end

  assign STRAP_O = strap_ff;

  // Checks
  sequence s_pg_rise;
    pin_rise[`SCRU_PIN_PG] && state_ff == ST_OFF;
  endsequence

  sequence s_seq_to_lock;
    state_ff == ST_CAPTURE ##1 state_ff == ST_LOCK;
  endsequence

  property p_pg_low_reset;
    @(posedge REF_CLK_I) disable iff (!ARST_N_I)
    !pin_filt_ff[`SCRU_PIN_PG] |=> !BOARD_RESET_OUT_N_O && state_ff == ST_OFF;
  endproperty
  a_pg_low_reset: assert property (p_pg_low_reset)
    else $error("board reset not asserted while power good low");

  property p_hard_reset_start;
    @(posedge REF_CLK_I) disable iff (!ARST_N_I)
    s_pg_rise |=> s_seq_to_lock;
  endproperty
  a_hard_reset_start: assert property (p_hard_reset_start)
    else $error("power good rise did not start hard reset");

  property p_strap_capture;
    @(posedge REF_CLK_I) disable iff (!ARST_N_I)
    state_ff == ST_CAPTURE |=> strap_ff == $past(md_s3_ff);
  endproperty
  a_strap_capture: assert property (p_strap_capture)
    else $error("straps not captured from memory data");

  property p_release_on_host;
    @(posedge REF_CLK_I) disable iff (!ARST_N_I)
    $rose(BOARD_RESET_OUT_N_O) |-> $past(nco_rise.host) && locked_ff;
  endproperty
  a_release_on_host: assert property (p_release_on_host)
    else $error("board reset released off host edge or unlocked");

  property p_gfx_dir;
    @(posedge REF_CLK_I) disable iff (!ARST_N_I)
    gfx_ext [*2] |-> !GRAPHICS_DOUBLE_CLOCK_OE_O;
  endproperty
  a_gfx_dir: assert property (p_gfx_dir)
    else $error("graphics clock pin driven while strapped external");

  property p_dot_dir;
    @(posedge REF_CLK_I) disable iff (!ARST_N_I)
    !dot_ext [*3] |-> PIXEL_DOT_CLOCK_OE_O;
  endproperty
  a_dot_dir: assert property (p_dot_dir)
    else $error("dot clock pin not driven in internal mode");

  property p_periph_spacing;
    @(posedge REF_CLK_I) disable iff (!ARST_N_I || !locked_ff)
    nco_rise.periph |=> !nco_rise.periph [*7] ##[1:2] nco_rise.periph;
  endproperty
  a_periph_spacing: assert property (p_periph_spacing)
    else $error("peripheral clock period wrong");

  property p_exp_pair;
    @(posedge REF_CLK_I) disable iff (!ARST_N_I)
    $changed(EXPANSION_BUS_CLOCK_O) |-> $rose(EXPANSION_BUS_CLOCK_X2_O);
  endproperty
  a_exp_pair: assert property (p_exp_pair)
    else $error("expansion clock not half of companion");

  property p_host_tick;
    @(posedge REF_CLK_I) disable iff (!ARST_N_I)
    HOST_TICK_O |-> HOST_CLOCK_O ##1 !HOST_TICK_O;
  endproperty
  a_host_tick: assert property (p_host_tick)
    else $error("host tick not a single cycle on host rise");
endmodule
`default_nettype wire

/* File: scru_regs.svh */
`ifndef SCRU_REGS_SVH
`define SCRU_REGS_SVH
// Core clock rate and derived settle time
`define SCRU_CLK_MHZ        200
`define SCRU_SETTLE_NS      1000
`define SCRU_SETTLE_CYC     ((`SCRU_SETTLE_NS * `SCRU_CLK_MHZ + 999) / 1000)
// Crystal edges seen before the synthesizer counts as locked
`define SCRU_LOCK_EDGES     1024
`define SCRU_LOCK_W         11
// Phase accumulator width and fixed increments (inc = 2*f/200MHz * 2^16)
`define SCRU_NCO_W          16
`define SCRU_INC_PERIPH     16'h3D71
`define SCRU_INC_GFX        16'hCCCD
`define SCRU_INC_LBUS       16'h547B
`define SCRU_INC_HOST_MIN   16'h4000
`define SCRU_INC_HOST_MAX   16'hC000
// Synthesizer channel indices
`define SCRU_NUM_CLK        5
`define SCRU_IDX_HOST       0
`define SCRU_IDX_PERIPH     1
`define SCRU_IDX_GFX        2
`define SCRU_IDX_DOT        3
`define SCRU_IDX_LBUS       4
// Strap capture layout
`define SCRU_STRAP_W        41
`define SCRU_STRAP_GFX_EXT  24
`define SCRU_STRAP_DOT_EXT  25
// Expansion bus divider
`define SCRU_EXP_DIV        4
`define SCRU_EXP_CNT_W      8
// Pin synchroniser lanes
`define SCRU_PIN_W          5
`define SCRU_PIN_PG         0
`define SCRU_PIN_XTAL       1
`define SCRU_PIN_LBUS       2
`define SCRU_PIN_GFX        3
`define SCRU_PIN_DOT        4
`endif

/* File: scru_pkg.sv */
package scru_pkg;
  typedef enum logic [4:0] {
    ST_OFF     = 5'h01,
    ST_CAPTURE = 5'h02,
    ST_LOCK    = 5'h04,
    ST_SETTLE  = 5'h08,
    ST_RUN     = 5'h10
  } scru_state_t;
  typedef struct packed {
    logic lbus;
    logic dot;
    logic gfx;
    logic periph;
    logic host;
  } scru_clk_vec_t;
endpackage

/* File: scru_nco.sv */
`timescale 1ns/1ps
`default_nettype none
`include "scru_regs.svh"
module scru_nco #(
  parameter int W = `SCRU_NCO_W
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic         run_i,
  input  wire logic [W-1:0] inc_i,
  output var  logic         clk_o,
  output var  logic         rise_o
);
  logic [W-1:0] acc_ff;
  logic [W:0]   sum;

  // Carry out of the accumulator marks each half period
  assign sum = {1'b0, acc_ff} + {1'b0, inc_i};

  // Accumulator; stopped while the reference is not locked
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      acc_ff <= '0;
    else if (run_i)
      acc_ff <= sum[W-1:0];
  end

  // Output toggles on carry, rise flagged in the same cycle
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      clk_o  <= 1'b0;
      rise_o <= 1'b0;
    end
    else
    begin
      rise_o <= run_i & sum[W] & ~clk_o;
      if (run_i && sum[W])
        clk_o <= ~clk_o;
    end
  end
endmodule
`default_nettype wire

/* File: scru_board_model.sv */
`timescale 1ns/1ps
`default_nettype none
module scru_board_model (
  input  wire logic run_i,
  output var  logic osc_o,
  output var  logic osc_n_o,
  output var  logic gfx_ext_o,
  output var  logic dot_ext_o
);
  // Oscillator stands still low while stopped, so no stray edge reaches the lock counter
  initial
  begin
    osc_o = 1'b0;
    forever
    begin
      #34.921;
      osc_o = run_i ? ~osc_o : 1'b0;
    end
  end
  assign osc_n_o = ~osc_o;
  // External graphics source, slow enough for a 200 MHz sampler
  initial
  begin
    gfx_ext_o = 1'b0;
    forever #20.0 gfx_ext_o = ~gfx_ext_o;
  end
  // Composite video dot source at 27 MHz
  initial
  begin
    dot_ext_o = 1'b0;
    forever #18.519 dot_ext_o = ~dot_ext_o;
  end
endmodule
`default_nettype wire

/* File: tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "scru_regs.svh"
module tb;
  import scru_pkg::*;
  localparam logic [40:0] PAT_INT = 41'h155AA33CCF0 & ~(41'h3 << `SCRU_STRAP_GFX_EXT);
  localparam logic [40:0] PAT_EXT = PAT_INT | (41'h3 << `SCRU_STRAP_GFX_EXT);
  logic        ref_clk;
  logic        arst_n;
  logic        pg;
  logic        osc_run;
  logic [15:0] host_inc;
  logic [15:0] dot_inc;
  logic        dot_sel;
  logic        exp_lbus;
  logic [40:0] mem_data;
  wire logic   osc, osc_n, gfx_ext, dot_ext, gfx_o, gfx_oe, dot_o, dot_oe, xtal_oe;
  wire logic   lbus_clk, board_rst_n, host_tick;
  wire logic   [10:0] mon;
  wire logic   [40:0] strap;
  wire logic   gfx_pin = gfx_oe ? gfx_o : gfx_ext;
  wire logic   dot_pin = dot_oe ? dot_o : dot_ext;
  int          failures;
  int          samples_checked;

  // Core clock, 200 MHz
  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  scru_board_model u_board (.run_i(osc_run), .osc_o(osc), .osc_n_o(osc_n),
    .gfx_ext_o(gfx_ext), .dot_ext_o(dot_ext));

  scru_top #(.LOCK_EDGES(4), .EXP_DIV(4)) u_dut (
    .REF_CLK_I(ref_clk), .ARST_N_I(arst_n), .POWER_GOOD_RESET_IN_I(pg),
    .CRYSTAL_IN_I(osc_n), .CRYSTAL_OUT_OSC_IN_I(osc), .CRYSTAL_OUT_OSC_IN_O(mon[8]),
    .CRYSTAL_OUT_OSC_IN_OE_O(xtal_oe), .HOST_INC_I(host_inc), .DOT_INC_I(dot_inc),
    .DOT_EXT_SEL_I(dot_sel), .EXP_SRC_LBUS_I(exp_lbus), .MEM_DATA_I(mem_data),
    .LOCAL_BUS_CLOCK_IN_I(lbus_clk),
    .GRAPHICS_DOUBLE_CLOCK_I(gfx_pin), .GRAPHICS_DOUBLE_CLOCK_O(gfx_o),
    .GRAPHICS_DOUBLE_CLOCK_OE_O(gfx_oe), .PIXEL_DOT_CLOCK_I(dot_pin),
    .PIXEL_DOT_CLOCK_O(dot_o), .PIXEL_DOT_CLOCK_OE_O(dot_oe), .HOST_CLOCK_O(mon[7]),
    .HOST_TICK_O(mon[0]), .GFX_TICK_O(mon[1]), .DOT_TICK_O(mon[2]),
    .PERIPHERAL_24M_CLOCK_O(mon[3]), .LOCAL_BUS_CLOCK_OUT_O(lbus_clk),
    .BUFFERED_CRYSTAL_CLOCK_O(mon[4]), .EXPANSION_BUS_CLOCK_O(mon[5]),
    .EXPANSION_BUS_CLOCK_X2_O(mon[6]), .BOARD_RESET_OUT_N_O(board_rst_n),
    .STRAP_O(strap));
  assign host_tick = mon[0];
  // Pin-side clocks joined to the monitor lanes for rate checks
  assign mon[9]  = gfx_o;
  assign mon[10] = dot_o;

  task automatic final_report();
    $display("Counts: %0d mismatches, %0d checks", failures, samples_checked);
    if (failures == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic check(input logic ok, input string msg);
    samples_checked++;
    if (ok !== 1'b1)
    begin
      failures++;
      $display("MISMATCH t=%0t %s", $time, msg);
    end
  endtask

  // Rise count on one monitored line against a nominal rate in kHz
  task automatic measure(input int idx, input int ncyc, input int khz, input int tol,
                         input string msg);
    logic prev;
    int   n;
    int   expd;
    n    = 0;
    expd = ncyc * 5 * khz / 1000000;
    prev = mon[idx];
    repeat (ncyc)
    begin
      @(posedge ref_clk);
      #1;
      if (mon[idx] === 1'b1 && prev === 1'b0)
        n++;
      prev = mon[idx];
    end
    check(n >= expd - tol && n <= expd + tol, msg);
  endtask

  task automatic power_up(input logic [40:0] pattern);
    @(posedge ref_clk);
    pg <= 1'b0;
    repeat (10) @(posedge ref_clk);
    #1;
    check(board_rst_n === 1'b0, "board reset not forced by power-good low");
    @(posedge ref_clk);
    mem_data <= pattern;
    pg       <= 1'b1;
  endtask

  // Bounded wait for board reset release, then straps and release moment
  task automatic wait_release(input logic [40:0] pattern);
    int n;
    n = 0;
    while (board_rst_n !== 1'b1 && n < 3000)
    begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    if (n >= 3000)
    begin
      failures++;
      $display("MISMATCH t=%0t board reset never released", $time);
      final_report();
    end
    check(n >= 200, "board reset released before settle time");
    check(host_tick === 1'b1, "release not aligned to host clock");
    check(strap === pattern, "strap capture wrong");
  endtask

  task automatic t_internal_clocks();
    int inc_tab [5] = '{32'h0000, 32'h4000, 32'h8000, 32'hC000, 32'hFFFF};
    int khz_tab [5] = '{25000, 25000, 50000, 75000, 75000};
    power_up(PAT_INT);
    wait_release(PAT_INT);
    check(gfx_oe === 1'b1 && dot_oe === 1'b1, "clock pins not driven");
    check(xtal_oe === 1'b1, "oscillator amplifier off");
    for (int i = 0; i < 5; i++)
    begin
      @(posedge ref_clk);
      host_inc <= inc_tab[i][15:0];
      repeat (20) @(posedge ref_clk);
      measure(0, 800, khz_tab[i], 2, "host clock rate");
    end
    measure(7, 800, 75000, 2, "host clock pin rate");
    measure(3, 1000, 24000, 2, "peripheral clock rate");
    measure(1, 1000, 80000, 3, "graphics clock rate");
    measure(9, 1000, 80000, 3, "graphics clock pin rate");
    measure(2, 1000, 25000, 2, "internal dot clock rate");
    measure(10, 1000, 25000, 2, "dot clock pin rate");
    measure(4, 2000, 14318, 2, "buffered crystal rate");
    measure(8, 2000, 14318, 2, "crystal amplifier rate");
    $display("test internal_clocks done");
  endtask

  task automatic t_expansion();
    measure(6, 4000, 1789, 2, "expansion x2 from crystal");
    measure(5, 4000, 894, 2, "expansion base from crystal");
    @(posedge ref_clk);
    exp_lbus <= 1'b1;
    repeat (100) @(posedge ref_clk);
    measure(6, 4000, 4125, 3, "expansion x2 from local bus");
    measure(5, 4000, 2062, 2, "expansion base from local bus");
    $display("test expansion done");
  endtask

  task automatic t_external_clocks();
    @(posedge ref_clk);
    dot_sel <= 1'b1;
    repeat (20) @(posedge ref_clk);
    check(dot_oe === 1'b0, "dot pin still driven");
    measure(2, 1000, 27000, 3, "external dot clock rate");
    @(posedge ref_clk);
    dot_sel <= 1'b0;
    power_up(PAT_EXT);
    wait_release(PAT_EXT);
    check(gfx_oe === 1'b0 && dot_oe === 1'b0, "strap did not free pins");
    measure(1, 1000, 25000, 3, "external graphics clock rate");
    $display("test external_clocks done");
  endtask

  task automatic t_no_crystal();
    int highs;
    highs = 0;
    @(posedge ref_clk);
    osc_run <= 1'b0;
    power_up(PAT_INT);
    repeat (600)
    begin
      @(posedge ref_clk);
      #1;
      if (board_rst_n !== 1'b0)
        highs++;
    end
    check(highs == 0, "released without crystal reference");
    @(posedge ref_clk);
    osc_run <= 1'b1;
    wait_release(PAT_INT);
    $display("test no_crystal done");
  endtask

  // Main sequence: reset, then scenarios
  initial
  begin
    failures        = 0;
    samples_checked = 0;
    arst_n   = 1'b0;
    pg       = 1'b0;
    osc_run  = 1'b1;
    host_inc = 16'h4000;
    dot_inc  = 16'h4000;
    dot_sel  = 1'b0;
    exp_lbus = 1'b0;
    mem_data = 41'h0;
    repeat (10) @(posedge ref_clk);
    #1;
    check(board_rst_n === 1'b0 && xtal_oe === 1'b0, "outputs active in reset");
    @(posedge ref_clk);
    arst_n <= 1'b1;
    t_internal_clocks();
    t_expansion();
    t_external_clocks();
    t_no_crystal();
    final_report();
  end
endmodule
`default_nettype wire
